// >>> src/qdma_status_cfg.svh
// Purpose: Offsets, field positions, reset values for the queued read status
// Assumes: APB byte addresses, one aligned word per register
// Notes: Definitions only
`ifndef QDMA_STATUS_CFG_SVH
`define QDMA_STATUS_CFG_SVH

`define OFF_ERROR_FLAGS 12'h000
`define OFF_SECTOR_COUNT_TAG 12'h004
`define OFF_ADDRESS_LOW 12'h008
`define OFF_ADDRESS_MID 12'h00c
`define OFF_ADDRESS_HIGH 12'h010
`define OFF_UNIT_SELECT_REG 12'h014
`define OFF_STATUS_FLAGS 12'h018
`define OFF_CONTROL 12'h01c
`define OFF_EVENT 12'h020
`define OFF_CONFIG 12'h024

// Status bit positions
`define ST_BUSY 7
`define ST_READY 6
`define ST_FAULT 5
`define ST_QATTN 4
`define ST_XFER 3
`define ST_FAIL 0

// Error bit positions
`define ER_LINK_CRC 7
`define ER_UNC 6
`define ER_MCHG 5
`define ER_ADDRESS_NOT_FOUND 4
`define ER_MCREQ 3
`define ER_COMMAND_ABORTED 2
`define ER_NOMED 1

// Sector count low bits
`define SC_FREED 2
`define SC_TOHOST 1
`define SC_CPHASE 0

// Control register bits (HOB, UNIT stored on every write; others write one to act)
`define CT_HOB 0
`define CT_UNIT 1
`define CT_ISSUE 2
`define CT_SERVICE 3
`define CT_CLR_MCR 4

// Event register bits (write one to report)
`define EV_DATA_READY 0
`define EV_DONE_OK 1
`define EV_FAIL 2
`define EV_RELEASE 3
`define EV_OTHER_READY 4
`define EV_OTHER_NONE 5
`define EV_FAULT 6

// Config register bits
`define CF_QUEUING 0
`define CF_OVERLAP 1
`define CF_REMOVABLE 2
`define CF_SUPPORTED 3

`define STATUS_RESET 8'h40
`define APB_AW 12

`endif

// >>> src/qdma_status_pkg.sv
// Purpose: Types for the queued read status block
// Assumes: Constants live in qdma_status_cfg.svh
// Notes: States and error cause bundle
package qdma_status_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_XFER = 3'b001,
        ST_RELEASED = 3'b010,
        ST_SERVICE_WAIT = 3'b011,
        ST_DONE = 3'b100,
        ST_ERROR = 3'b101
    } phase_t;

    typedef enum logic [1:0] {
        PEND_NONE = 2'b00,
        PEND_DATA = 2'b01,
        PEND_DONE = 2'b10,
        PEND_FAIL = 2'b11
    } pending_t;

    typedef struct packed {
        logic link_crc;
        logic ultra_dma;
        logic uncorrectable;
        logic not_found;
        logic out_of_range;
        logic range_abort;
        logic cannot_complete;
        logic unsupported;
    } fault_cause_t;

endpackage

// >>> src/queued_dma_read_status.sv
// Purpose: Register-level status of a queued overlapped 48-bit DMA read
// Assumes: APB slave, zero wait states, pslverr on unmapped addresses
// Notes: Media engine reports events through pins or the event register
// Functional notes
// RULE_01: After release, service need sets only queued_attention.
// RULE_02: Service command presents data, completion or error register set.
// RULE_03: Completion and error show tag, freed clear, to-host and phase set.
// RULE_04: Tag 0..31 accepted; report 00h without queuing or overlap.
// RULE_05: Completion clears busy, transfer, fault, failure; sets ready.
// RULE_06: Completion sets queued_attention only if another command is ready.
// RULE_07: Abort if command unsupported or overlap interrupt not enabled.
// RULE_08: Abort when queuing is supported and the tag is invalid.
// RULE_09: Unrecoverable error ends command, latches failing address, aborts queue.
// RULE_10: Address readback bytes chosen by high_order_byte_select.
// RULE_11: Set link_checksum_error on Ultra DMA CRC error only.
// RULE_12: Set data_not_correctable and address_not_found on their causes.
// RULE_13: Report medium_changed once, then clear internal detected state.
// RULE_14: medium_change_request clears only on media status or access.
// RULE_15: Set command_aborted on unsupported, Ultra DMA error, range abort.
// RULE_16: Removable device sets no_medium when no media present.
// RULE_17: Error output: busy, transfer clear; ready set; fault, failure on cause. The code never sets fault for an error served after a release.
// RULE_18: High select shows high bytes; high sector count reads reserved.
// RULE_19: unit_select always shows the selected device.
// RULE_20: Host checks unit_ready and sets up its DMA channel first.
// RULE_21: Device may release bus or transfer at once when data ready.
// RULE_22: Transfer start shows tag, freed clear, to-host, data phase.
// RULE_23: Release sets bus_freed; queued_attention once ready for service.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "qdma_status_cfg.svh"

module queued_dma_read_status
    import qdma_status_pkg::*;
#(
    parameter int TAG_W = 5,
    parameter int MAX_TAG = 31
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [47:0] fail_address,
    input wire fault_cause_t fail_cause,
    input wire logic media_changed_event,
    input wire logic media_change_req_event,
    input wire logic media_present,
    input wire logic media_access_cmd,
    output logic queue_abort,
    output logic transfer_go,
    output logic [TAG_W-1:0] active_tag
);

    phase_t phase_r;
    pending_t pend_r;
    logic hob_r;
    logic unit_r;
    logic [TAG_W-1:0] tag_r;
    logic [7:0] status_r;
    logic [7:0] error_r;
    logic [2:0] sc_low_r;
    logic [47:0] fail_addr_r;
    logic media_chg_seen_r;
    logic mcr_r;
    logic queuing_r;
    logic overlap_r;
    logic removable_r;
    logic supported_r;
    logic other_ready_r;

    logic wr_en;
    logic rd_en;
    logic ctl_wr;
    logic ev_wr;
    logic issue;
    logic service;
    logic ev_data;
    logic ev_ok;
    logic ev_fail;
    logic ev_rel;
    logic tag_ok;
    logic [7:0] tag_byte;
    logic [7:0] err_nxt;
    logic [7:0] rd_byte;
    logic mapped;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign ctl_wr = wr_en && paddr == `OFF_CONTROL;
    assign ev_wr = wr_en && paddr == `OFF_EVENT;
    assign issue = ctl_wr && pwdata[`CT_ISSUE];
    assign service = ctl_wr && pwdata[`CT_SERVICE];
    assign ev_data = ev_wr && pwdata[`EV_DATA_READY];
    assign ev_ok = ev_wr && pwdata[`EV_DONE_OK];
    assign ev_fail = ev_wr && pwdata[`EV_FAIL];
    assign ev_rel = ev_wr && pwdata[`EV_RELEASE];
    assign tag_ok = 32'(pwdata[15:8]) <= MAX_TAG;
    assign queue_abort = phase_r == ST_ERROR && queuing_r; // RULE_09
    assign transfer_go = phase_r == ST_XFER;
    assign active_tag = tag_r;

    // Whole byte reads 00h without queuing or overlap
    always_comb
    begin
        tag_byte = 8'h00;
        if (queuing_r && overlap_r) // RULE_04
        begin
            tag_byte[7:3] = 5'(tag_r);
            tag_byte[2:0] = sc_low_r;
        end
    end

    // Error bits built from the reported cause, the media state and the removable setting
    always_comb
    begin
        err_nxt = 8'h00;
        err_nxt[`ER_LINK_CRC] = fail_cause.link_crc
            && fail_cause.ultra_dma; // RULE_11
        err_nxt[`ER_UNC] = fail_cause.uncorrectable; // RULE_12
        err_nxt[`ER_ADDRESS_NOT_FOUND] = fail_cause.not_found
            || (fail_cause.out_of_range && !fail_cause.range_abort); // RULE_12
        err_nxt[`ER_COMMAND_ABORTED] = fail_cause.unsupported
            || (fail_cause.ultra_dma && fail_cause.link_crc)
            || (fail_cause.out_of_range && fail_cause.range_abort)
            || fail_cause.cannot_complete; // RULE_15
        err_nxt[`ER_MCHG] = removable_r && media_chg_seen_r; // RULE_13
        err_nxt[`ER_MCREQ] = removable_r && mcr_r; // RULE_14
        err_nxt[`ER_NOMED] = removable_r && !media_present; // RULE_16
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            queuing_r <= 1'b0;
            overlap_r <= 1'b0;
            removable_r <= 1'b0;
            supported_r <= 1'b0;
        end
        else if (wr_en && paddr == `OFF_CONFIG)
        begin
            queuing_r <= pwdata[`CF_QUEUING];
            overlap_r <= pwdata[`CF_OVERLAP];
            removable_r <= pwdata[`CF_REMOVABLE];
            supported_r <= pwdata[`CF_SUPPORTED];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hob_r <= 1'b0;
            unit_r <= 1'b0;
        end
        else if (ctl_wr)
        begin
            hob_r <= pwdata[`CT_HOB]; // RULE_18
            unit_r <= pwdata[`CT_UNIT]; // RULE_19
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            other_ready_r <= 1'b0;
        end
        else if (ev_wr && pwdata[`EV_OTHER_READY])
        begin
            other_ready_r <= 1'b1;
        end
        else if (ev_wr && pwdata[`EV_OTHER_NONE])
        begin
            other_ready_r <= 1'b0;
        end
    end

    // Media state: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            media_chg_seen_r <= 1'b0;
            mcr_r <= 1'b0;
        end
        else
        begin
            if (media_changed_event)
            begin
                media_chg_seen_r <= 1'b1;
            end
            else if (issue || (ev_fail && removable_r))
            begin
                media_chg_seen_r <= 1'b0; // RULE_13
            end
            if (media_change_req_event)
            begin
                mcr_r <= 1'b1;
            end
            else if (media_access_cmd
                || (ctl_wr && pwdata[`CT_CLR_MCR]))
            begin
                mcr_r <= 1'b0; // RULE_14
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_r <= ST_IDLE;
            pend_r <= PEND_NONE;
            tag_r <= '0;
            status_r <= `STATUS_RESET;
            error_r <= 8'h00;
            sc_low_r <= 3'b000;
            fail_addr_r <= 48'h0;
        end
        else
        begin
            case (phase_r)
                ST_IDLE, ST_DONE, ST_ERROR:
                begin
                    if (issue) // RULE_20
                    begin
                        tag_r <= TAG_W'(pwdata[15:8]); // RULE_04
                        if (!supported_r || !overlap_r
                            || (queuing_r && !tag_ok)) // RULE_07 RULE_08
                        begin
                            phase_r <= ST_ERROR;
                            sc_low_r <= 3'b011; // RULE_03
                            error_r <= 8'h00 | (8'h01 << `ER_COMMAND_ABORTED);
                            status_r <= 8'h00 | (8'h01 << `ST_READY)
                                | (8'h01 << `ST_FAIL);
                        end
                        else
                        begin
                            phase_r <= ST_XFER;
                            sc_low_r <= 3'b000;
                            error_r <= 8'h00;
                            status_r <= 8'h00 | (8'h01 << `ST_BUSY);
                        end
                    end
                end
                ST_XFER:
                begin
                    if (ev_rel) // RULE_21 RULE_23
                    begin
                        phase_r <= ST_RELEASED;
                        sc_low_r <= 3'b000 | (3'b001 << `SC_FREED)
                            | (3'b001 << `SC_TOHOST);
                        status_r <= 8'h00 | (8'h01 << `ST_READY);
                    end
                    else if (ev_data) // RULE_21 RULE_22
                    begin
                        sc_low_r <= 3'b000 | (3'b001 << `SC_TOHOST);
                        status_r <= 8'h00 | (8'h01 << `ST_READY);
                    end
                    else if (ev_ok)
                    begin
                        phase_r <= ST_DONE;
                        sc_low_r <= 3'b011; // RULE_03
                        status_r <= 8'h00 | (8'h01 << `ST_READY)
                            | (8'(other_ready_r) << `ST_QATTN); // RULE_05 RULE_06
                    end
                    else if (ev_fail)
                    begin
                        phase_r <= ST_ERROR; // RULE_09
                        fail_addr_r <= fail_address; // RULE_09
                        error_r <= err_nxt;
                        sc_low_r <= 3'b011; // RULE_03
                        status_r <= 8'h00 | (8'h01 << `ST_READY)
                            | (8'(pwdata[`EV_FAULT]) << `ST_FAULT)
                            | (8'(|err_nxt) << `ST_FAIL); // RULE_17
                    end
                end
                ST_RELEASED:
                begin
                    if (ev_data || ev_ok || ev_fail)
                    begin
                        phase_r <= ST_SERVICE_WAIT;
                        pend_r <= ev_fail ? PEND_FAIL
                            : (ev_ok ? PEND_DONE : PEND_DATA);
                        if (ev_fail)
                        begin
                            fail_addr_r <= fail_address;
                            error_r <= err_nxt;
                        end
                        status_r[`ST_QATTN] <= 1'b1; // RULE_01
                    end
                end
                ST_SERVICE_WAIT:
                begin
                    if (service) // RULE_02
                    begin
                        case (pend_r)
                            PEND_DATA:
                            begin
                                phase_r <= ST_XFER;
                                sc_low_r <= 3'b010; // RULE_22
                                status_r <= 8'h00 | (8'h01 << `ST_READY);
                            end
                            PEND_DONE:
                            begin
                                phase_r <= ST_DONE;
                                sc_low_r <= 3'b011;
                                status_r <= 8'h00 | (8'h01 << `ST_READY)
                                    | (8'(other_ready_r) << `ST_QATTN);
                            end
                            default:
                            begin
                                phase_r <= ST_ERROR;
                                sc_low_r <= 3'b011;
                                status_r <= 8'h00 | (8'h01 << `ST_READY)
                                    | (8'(|error_r) << `ST_FAIL);
                            end
                        endcase
                        pend_r <= PEND_NONE;
                    end
                end
                default:
                begin
                    phase_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Readback mux
    always_comb
    begin
        rd_byte = 8'h00;
        mapped = 1'b1;
        case (paddr)
            `OFF_ERROR_FLAGS:
                rd_byte = error_r
                    & ~(8'(!mcr_r) << `ER_MCREQ); // RULE_14
            `OFF_SECTOR_COUNT_TAG: rd_byte = hob_r ? 8'h00 : tag_byte; // RULE_18
            `OFF_ADDRESS_LOW:
                rd_byte = hob_r ? fail_addr_r[31:24]
                    : fail_addr_r[7:0]; // RULE_10
            `OFF_ADDRESS_MID:
                rd_byte = hob_r ? fail_addr_r[39:32]
                    : fail_addr_r[15:8]; // RULE_10
            `OFF_ADDRESS_HIGH:
                rd_byte = hob_r ? fail_addr_r[47:40]
                    : fail_addr_r[23:16]; // RULE_10
            `OFF_UNIT_SELECT_REG: rd_byte = 8'(unit_r) << 4; // RULE_19
            `OFF_STATUS_FLAGS: rd_byte = status_r;
            `OFF_CONTROL: rd_byte = {7'h00, hob_r} | (8'(unit_r) << `CT_UNIT);
            `OFF_EVENT: rd_byte = {5'h00, phase_r};
            `OFF_CONFIG:
                rd_byte = {4'h0, supported_r, removable_r, overlap_r,
                    queuing_r};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= (psel && !penable && !pwrite) ? {24'h0, rd_byte}
                : prdata;
            pslverr <= psel && !penable && !mapped;
        end
    end

endmodule

// >>> tb/qdma_status_checker.sv
// Purpose: Port-level checks of the queued read status block
// Assumes: APB slave with pready tied high, one clock
// Notes: Bound into every instance of the block
`timescale 1ns/100ps
`include "qdma_status_cfg.svh"

module qdma_status_checker
    import qdma_status_pkg::*;
#(
    parameter int TAG_W = 5,
    parameter int MAX_TAG = 31
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [47:0] fail_address,
    input wire fault_cause_t fail_cause,
    input wire logic media_changed_event,
    input wire logic media_change_req_event,
    input wire logic media_present,
    input wire logic media_access_cmd,
    input wire logic queue_abort,
    input wire logic transfer_go,
    input wire logic [TAG_W-1:0] active_tag
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    ready_high_a: assert property (pready)
        else $error("pready low");
    err_unmapped_a: assert property (psel && !penable
        && paddr > 12'h024 |=> pslverr) else $error("no slave error");
    err_mapped_a: assert property (psel && !penable && paddr <= 12'h024
        && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("slave error on mapped address");
    err_access_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite)
        |=> $stable(prdata)) else $error("read data moved");
    byte_only_a: assert property (prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    go_abort_a: assert property (!(transfer_go && queue_abort))
        else $error("transfer during queue abort");
    tag_hold_a: assert property (transfer_go && $past(transfer_go)
        |-> $stable(active_tag)) else $error("tag moved in transfer");
endmodule

bind queued_dma_read_status qdma_status_checker #(.TAG_W(TAG_W),
    .MAX_TAG(MAX_TAG)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fail_address(fail_address),
    .fail_cause(fail_cause), .media_changed_event(media_changed_event),
    .media_change_req_event(media_change_req_event),
    .media_present(media_present), .media_access_cmd(media_access_cmd),
    .queue_abort(queue_abort), .transfer_go(transfer_go),
    .active_tag(active_tag));

// >>> tb/media_engine_model.sv
// Purpose: Media side stand-in feeding failure data and media events
// Assumes: kick is a one-cycle code from the bench
// Notes: 1 raises a change request, 2 a media access, 3 a media change
`timescale 1ns/100ps

module media_engine_model
    import qdma_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] kick,
    output logic [47:0] fail_address,
    output fault_cause_t fail_cause,
    output logic media_changed_event,
    output logic media_change_req_event,
    output logic media_access_cmd
);
    // First failing sector and an Ultra DMA CRC error
    assign fail_address = 48'h665544332211;
    always_comb
    begin
        fail_cause = '0;
        fail_cause.link_crc = 1'b1;
        fail_cause.ultra_dma = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            media_changed_event <= 1'b0;
            media_change_req_event <= 1'b0;
            media_access_cmd <= 1'b0;
        end
        else
        begin
            media_changed_event <= (kick == 2'd3);
            media_change_req_event <= (kick == 2'd1);
            media_access_cmd <= (kick == 2'd2);
        end
    end
endmodule

// >>> tb/queued_dma_read_status_tb.sv
// Purpose: Register sequences for the queued read status block
// Assumes: APB master tasks, zero-wait slave, 25 MHz clock
// Notes: Expected bytes follow the status, error and tag layouts
`timescale 1ns/100ps
`include "qdma_status_cfg.svh"

module queued_dma_read_status_tb
    import qdma_status_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, queue_abort, transfer_go;
    logic [4:0] active_tag;
    logic [47:0] fail_address;
    fault_cause_t fail_cause;
    logic mcr_ev, acc_cmd, mc_ev;
    logic present = 1'b1;
    logic [1:0] kick = 2'd0;
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] q;
    logic e;

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    media_engine_model eng (.ref_clk(ref_clk), .rst_n(rst_n),
        .kick(kick), .fail_address(fail_address),
        .fail_cause(fail_cause), .media_changed_event(mc_ev),
        .media_change_req_event(mcr_ev),
        .media_access_cmd(acc_cmd));

    queued_dma_read_status dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fail_address(fail_address),
        .fail_cause(fail_cause), .media_changed_event(mc_ev),
        .media_change_req_event(mcr_ev), .media_present(present),
        .media_access_cmd(acc_cmd), .queue_abort(queue_abort),
        .transfer_go(transfer_go), .active_tag(active_tag));

    task test_done();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_fail++;
            $display("FAIL %0t no answer", $time);
            test_done();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x)
        begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, g, x);
        end
    endtask

    task chk1(input logic g, input logic x);
        tests_run++;
        if (g !== x)
        begin
            n_fail++;
            $display("FAIL %0t flag %b want %b", $time, g, x);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h00000000);
        chk(q[7:0], x);
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`OFF_STATUS_FLAGS, 8'h40);
        rd(12'h030, 8'h00);
        chk1(e, 1'b1);
        $display("test reset and map done");
        wr(`OFF_CONFIG, 32'h0000000b);
        wr(`OFF_CONTROL, 32'h00000002);
        rd(`OFF_UNIT_SELECT_REG, 8'h10);
        wr(`OFF_CONTROL, 32'h00001f06);
        @(negedge ref_clk);
        chk1(transfer_go, 1'b1);
        chk({3'b000, active_tag}, 8'h1f);
        wr(`OFF_EVENT, 32'h00000001);
        rd(`OFF_SECTOR_COUNT_TAG, 8'hfa);
        rd(`OFF_STATUS_FLAGS, 8'h40);
        wr(`OFF_EVENT, 32'h00000008);
        rd(`OFF_SECTOR_COUNT_TAG, 8'hfe);
        wr(`OFF_EVENT, 32'h00000001);
        rd(`OFF_STATUS_FLAGS, 8'h50);
        rd(`OFF_SECTOR_COUNT_TAG, 8'hfe);
        wr(`OFF_CONTROL, 32'h0000000a);
        rd(`OFF_SECTOR_COUNT_TAG, 8'hfa);
        wr(`OFF_EVENT, 32'h00000010);
        wr(`OFF_EVENT, 32'h00000002);
        rd(`OFF_STATUS_FLAGS, 8'h50);
        rd(`OFF_SECTOR_COUNT_TAG, 8'hfb);
        rd(`OFF_UNIT_SELECT_REG, 8'h10);
        $display("test queued completion done");
        wr(`OFF_CONFIG, 32'h00000009);
        wr(`OFF_CONTROL, 32'h00000306);
        rd(`OFF_STATUS_FLAGS, 8'h41);
        rd(`OFF_ERROR_FLAGS, 8'h04);
        rd(`OFF_SECTOR_COUNT_TAG, 8'h00);
        wr(`OFF_CONFIG, 32'h0000000b);
        wr(`OFF_CONTROL, 32'h00002006);
        rd(`OFF_STATUS_FLAGS, 8'h41);
        rd(`OFF_ERROR_FLAGS, 8'h04);
        rd(`OFF_SECTOR_COUNT_TAG, 8'h03);
        $display("test refused issue done");
        wr(`OFF_CONFIG, 32'h0000000f);
        wr(`OFF_CONTROL, 32'h00000506);
        present <= 1'b0;
        kick <= 2'd1;
        @(posedge ref_clk);
        kick <= 2'd3;
        @(posedge ref_clk);
        kick <= 2'd0;
        wr(`OFF_EVENT, 32'h00000044);
        rd(`OFF_ERROR_FLAGS, 8'hae);
        rd(`OFF_STATUS_FLAGS, 8'h61);
        rd(`OFF_SECTOR_COUNT_TAG, 8'h2b);
        rd(`OFF_ADDRESS_LOW, 8'h11);
        rd(`OFF_ADDRESS_MID, 8'h22);
        rd(`OFF_ADDRESS_HIGH, 8'h33);
        chk1(queue_abort, 1'b1);
        wr(`OFF_CONTROL, 32'h00000003);
        rd(`OFF_SECTOR_COUNT_TAG, 8'h00);
        rd(`OFF_ADDRESS_LOW, 8'h44);
        rd(`OFF_ADDRESS_MID, 8'h55);
        rd(`OFF_ADDRESS_HIGH, 8'h66);
        kick <= 2'd2;
        @(posedge ref_clk);
        kick <= 2'd0;
        rd(`OFF_ERROR_FLAGS, 8'ha6);
        $display("test failing read done");
        test_done();
    end
endmodule
